// ==== rtl/aec_pkg.sv ====
package aec_pkg;
    // Register byte offsets.
    localparam logic [5:0] OFS_STAT1   = 6'h00;
    localparam logic [5:0] OFS_CTRL1   = 6'h04;
    localparam logic [5:0] OFS_BSET1   = 6'h08;
    localparam logic [5:0] OFS_BCLR1   = 6'h0C;
    localparam logic [5:0] OFS_BSET2   = 6'h10;
    localparam logic [5:0] OFS_BCLR2   = 6'h14;
    localparam logic [5:0] OFS_EVLO    = 6'h18;
    localparam logic [5:0] OFS_EVHI    = 6'h1C;
    localparam logic [5:0] OFS_SSRST   = 6'h20;
    localparam logic [5:0] OFS_FCWIN   = 6'h24;
    localparam logic [5:0] OFS_RDINC   = 6'h28;
    // Field positions.
    localparam int BIT_DRDY       = 0;
    localparam int BIT_FULL       = 1;
    localparam int BIT_BUSY       = 2;
    localparam int BIT_GBUSY      = 3;
    localparam int BIT_SCOPE      = 4;
    localparam int BIT_MTEST      = 6;
    localparam int BIT_SWRST      = 7;
    localparam int BIT_CLRDATA    = 2;
    localparam int BIT_COUNT_ALL  = 14;
    // Implemented bits and reset values.
    localparam logic [15:0] CTRL1_MASK = 16'h0050;
    localparam logic [15:0] BSET1_MASK = 16'h0080;
    localparam logic [15:0] BSET2_MASK = 16'h4004;
    localparam logic [15:0] BSET2_RST  = 16'h4000;
    localparam logic [15:0] FCWIN_RST  = 16'h0028;
    localparam logic [7:0]  EOB_TAG    = 8'h04;
    // Timing.
    localparam int CLK_NS   = 5;
    localparam int CLEAR_NS = 600;
    localparam logic [7:0] CLEAR_CYC = 8'((CLEAR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [8:0] CONFIG_CYC = 9'h100;
    // Acquisition states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CLR  = 3'b100
    } aec_state_t;
endpackage : aec_pkg

// ==== rtl/aec_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module aec_ctrl (
    // Clock and reset.
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Avalon-MM slave.
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Front-panel control bus.
    input  wire logic        gate_in,
    input  wire logic        veto_in,
    input  wire logic        fast_clear_in,
    input  wire logic        reset_pulse_in,
    input  wire logic        chain_busy_in,
    input  wire logic        busy_scope_jumper_in,
    output logic             busy_out,
    output logic             busy_oe_out,
    output logic             busy_led_out,
    // Analog and buffer side.
    input  wire logic        conv_done_in,
    output logic             conv_start_out,
    output logic             conv_abort_out,
    output logic             peak_clear_out,
    output logic      [31:0] end_of_block_word_out,
    output logic             end_of_block_valid_out,
    output logic             data_ready_out
);
    typedef struct packed {
        logic [1:0]          gate_q;
        logic                gate_d;
        logic [1:0]          veto_q;
        logic [1:0]          fc_q;
        logic                fc_d;
        logic [1:0]          rst_q;
        logic                rst_d;
        logic [1:0]          cb_q;
        logic [1:0]          jmp_q;
        aec_pkg::aec_state_t fsm;
        logic [7:0]          tmr;
        logic [15:0]         fcw;
        logic [23:0]         evcnt;
        logic [4:0]          wptr;
        logic [4:0]          rptr;
        logic                last_wr;
        logic [15:0]         ctrl1;
        logic [15:0]         bset1;
        logic [15:0]         bset2;
        logic [15:0]         fcwin;
        logic                wait_r;
        logic [31:0]         rdata;
        logic                ss_wr;
        logic [8:0]          cfg;
        logic                busy;
        logic                led;
        logic                start;
        logic                abort;
        logic                pclr;
        logic [31:0]         end_of_block_word;
        logic                eob_v;
        logic                drdy;
    } aec_st_t;

    aec_st_t st_reg;
    aec_st_t st_next;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a[5:2] == ofs[5:2]);
    endfunction : hit

    function automatic logic [15:0] lanes(input logic [31:0] d, input logic [3:0] be);
        lanes = {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
    endfunction : lanes

    logic        full;
    logic        empty;
    logic        own_busy;
    logic        stop;
    logic        gate_rise;
    logic        fc_rise;
    logic        rst_rise;
    logic        sw_rst;
    logic        data_rst;
    logic        accept;
    logic        do_wr;
    logic [15:0] wd;
    logic [31:0] rd_mux;

    always_comb
    begin
        st_next = st_reg;
        full = (st_reg.wptr == st_reg.rptr) && st_reg.last_wr;
        empty = (st_reg.wptr == st_reg.rptr) && !st_reg.last_wr;
        gate_rise = st_reg.gate_q[1] && !st_reg.gate_d;
        fc_rise = st_reg.fc_q[1] && !st_reg.fc_d;
        rst_rise = st_reg.rst_q[1] && !st_reg.rst_d;
        sw_rst = st_reg.bset1[aec_pkg::BIT_SWRST] || st_reg.ss_wr
            || (rst_rise && st_reg.ctrl1[aec_pkg::BIT_SCOPE]);
        data_rst = sw_rst || st_reg.bset2[aec_pkg::BIT_CLRDATA] || rst_rise;
        own_busy = (st_reg.fsm != aec_pkg::ST_IDLE) || full
            || st_reg.ctrl1[aec_pkg::BIT_MTEST] || data_rst;
        stop = st_reg.jmp_q[1] ? (own_busy || st_reg.cb_q[1]) : own_busy;
        accept = gate_rise && !st_reg.veto_q[1] && !st_reg.fc_q[1] && !stop;
        do_wr = avs_write_in && !st_reg.wait_r;
        wd = lanes(avs_writedata_in, avs_byteenable_in);

        // Input synchronisers and edge history.
        st_next.gate_q = {st_reg.gate_q[0], gate_in};
        st_next.veto_q = {st_reg.veto_q[0], veto_in};
        st_next.fc_q = {st_reg.fc_q[0], fast_clear_in};
        st_next.rst_q = {st_reg.rst_q[0], reset_pulse_in};
        st_next.cb_q = {st_reg.cb_q[0], chain_busy_in};
        st_next.jmp_q = {st_reg.jmp_q[0], busy_scope_jumper_in};
        st_next.gate_d = st_reg.gate_q[1];
        st_next.fc_d = st_reg.fc_q[1];
        st_next.rst_d = st_reg.rst_q[1];

        // Event counter.
        if (st_reg.bset2[aec_pkg::BIT_COUNT_ALL] ? gate_rise : accept)
        begin
            st_next.evcnt = st_reg.evcnt + 24'h000001;
        end

        // Acquisition sequence.
        st_next.start = 1'b0;
        st_next.abort = 1'b0;
        st_next.eob_v = 1'b0;
        unique case (st_reg.fsm)
            aec_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    st_next.fsm = aec_pkg::ST_CONV;
                    st_next.fcw = st_reg.fcwin;
                    st_next.start = 1'b1;
                end
            end
            aec_pkg::ST_CONV:
            begin
                if (st_reg.fcw != 16'h0000)
                begin
                    st_next.fcw = st_reg.fcw - 16'h0001;
                end
                if (fc_rise && (st_reg.fcw != 16'h0000))
                begin
                    st_next.fsm = aec_pkg::ST_CLR;
                    st_next.tmr = aec_pkg::CLEAR_CYC - 8'h01;
                    st_next.abort = 1'b1;
                end
                else if (conv_done_in)
                begin
                    st_next.fsm = aec_pkg::ST_CLR;
                    st_next.tmr = aec_pkg::CLEAR_CYC - 8'h01;
                    st_next.end_of_block_word = {aec_pkg::EOB_TAG, st_reg.evcnt};
                    st_next.eob_v = 1'b1;
                    st_next.wptr = st_reg.wptr + 5'h01;
                    st_next.last_wr = 1'b1;
                end
            end
            aec_pkg::ST_CLR:
            begin
                if (st_reg.tmr == 8'h00)
                begin
                    st_next.fsm = aec_pkg::ST_IDLE;
                end
                else
                begin
                    st_next.tmr = st_reg.tmr - 8'h01;
                end
            end
        endcase

        // Event buffer read advance.
        if (do_wr && hit(avs_address_in, aec_pkg::OFS_RDINC) && !empty)
        begin
            st_next.rptr = st_reg.rptr + 5'h01;
            st_next.last_wr = 1'b0;
        end

        // Data reset wins over any count or pointer move.
        if (data_rst)
        begin
            st_next.evcnt = 24'h000000;
            st_next.wptr = 5'h00;
            st_next.rptr = 5'h00;
            st_next.last_wr = 1'b0;
            st_next.fsm = aec_pkg::ST_IDLE;
            st_next.fcw = 16'h0000;
            st_next.eob_v = 1'b0;
        end
        if (sw_rst)
        begin
            st_next.ctrl1 = 16'h0000;
            st_next.bset2 = aec_pkg::BSET2_RST;
            st_next.fcwin = aec_pkg::FCWIN_RST;
        end

        // Register writes.
        st_next.ss_wr = avs_write_in && hit(avs_address_in, aec_pkg::OFS_SSRST);
        if (do_wr)
        begin
            if (hit(avs_address_in, aec_pkg::OFS_CTRL1))
            begin
                st_next.ctrl1 = wd & aec_pkg::CTRL1_MASK;
            end
            if (hit(avs_address_in, aec_pkg::OFS_BSET1))
            begin
                st_next.bset1 = st_reg.bset1 | (wd & aec_pkg::BSET1_MASK);
            end
            if (hit(avs_address_in, aec_pkg::OFS_BCLR1))
            begin
                st_next.bset1 = st_reg.bset1 & ~wd;
            end
            if (hit(avs_address_in, aec_pkg::OFS_BSET2))
            begin
                st_next.bset2 = st_next.bset2 | (wd & aec_pkg::BSET2_MASK);
            end
            if (hit(avs_address_in, aec_pkg::OFS_BCLR2))
            begin
                st_next.bset2 = st_next.bset2 & ~wd;
            end
            if (hit(avs_address_in, aec_pkg::OFS_FCWIN))
            begin
                st_next.fcwin = wd;
            end
        end

        // Read data and wait handshake.
        rd_mux = 32'h00000000;
        if (hit(avs_address_in, aec_pkg::OFS_STAT1))
        begin
            rd_mux[aec_pkg::BIT_DRDY] = !empty;
            rd_mux[aec_pkg::BIT_FULL] = full;
            rd_mux[aec_pkg::BIT_BUSY] = st_reg.busy;
            rd_mux[aec_pkg::BIT_GBUSY] = st_reg.busy || st_reg.cb_q[1];
        end
        else if (hit(avs_address_in, aec_pkg::OFS_CTRL1))
            rd_mux[15:0] = st_reg.ctrl1;
        else if (hit(avs_address_in, aec_pkg::OFS_BSET1) || hit(avs_address_in, aec_pkg::OFS_BCLR1))
            rd_mux[15:0] = st_reg.bset1;
        else if (hit(avs_address_in, aec_pkg::OFS_BSET2) || hit(avs_address_in, aec_pkg::OFS_BCLR2))
            rd_mux[15:0] = st_reg.bset2;
        else if (hit(avs_address_in, aec_pkg::OFS_EVLO))
            rd_mux[15:0] = st_reg.evcnt[15:0];
        else if (hit(avs_address_in, aec_pkg::OFS_EVHI))
            rd_mux[7:0] = st_reg.evcnt[23:16];
        else if (hit(avs_address_in, aec_pkg::OFS_FCWIN))
            rd_mux[15:0] = st_reg.fcwin;
        if (avs_read_in && st_reg.wait_r)
        begin
            st_next.rdata = rd_mux;
        end
        st_next.wait_r = !((avs_read_in || avs_write_in) && st_reg.wait_r);

        // Outputs.
        if (st_reg.cfg != 9'h000)
        begin
            st_next.cfg = st_reg.cfg - 9'h001;
        end
        st_next.busy = own_busy;
        st_next.led = own_busy || (st_reg.cfg != 9'h000);
        st_next.pclr = data_rst || st_reg.fsm == aec_pkg::ST_CLR;
        st_next.drdy = !empty;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= '{fsm: aec_pkg::ST_IDLE, bset2: aec_pkg::BSET2_RST,
                        fcwin: aec_pkg::FCWIN_RST, cfg: aec_pkg::CONFIG_CYC,
                        wait_r: 1'b1, led: 1'b1, default: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_out = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.wait_r;
    assign busy_out = st_reg.busy;
    assign busy_oe_out = st_reg.busy;
    assign busy_led_out = st_reg.led;
    assign conv_start_out = st_reg.start;
    assign conv_abort_out = st_reg.abort;
    assign peak_clear_out = st_reg.pclr;
    assign end_of_block_word_out = st_reg.end_of_block_word;
    assign end_of_block_valid_out = st_reg.eob_v;
    assign data_ready_out = st_reg.drdy;

    // Checks run on the system clock and pause during reset.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_count_all: assert property (st_reg.bset2[aec_pkg::BIT_COUNT_ALL] && gate_rise
        && !data_rst |=> st_reg.evcnt == $past(st_reg.evcnt) + 24'h000001)
        else $error("gate not counted in count-all mode");
    a_count_step: assert property (st_reg.evcnt != $past(st_reg.evcnt) |->
        st_reg.evcnt == $past(st_reg.evcnt) + 24'h000001 || st_reg.evcnt == 24'h000000)
        else $error("event counter moved by other than one");
    a_count_acc: assert property (!st_reg.bset2[aec_pkg::BIT_COUNT_ALL] && !accept
        && !data_rst |=> $stable(st_reg.evcnt))
        else $error("refused gate counted in accepted mode");
    a_busy_pin: assert property (st_reg.fsm != aec_pkg::ST_IDLE |=> busy_out
        && busy_oe_out && busy_led_out)
        else $error("busy not shown while converting");
    a_gate_lock: assert property (own_busy |=> !conv_start_out)
        else $error("acquisition started while busy");
    a_fc_abort: assert property (st_reg.fsm == aec_pkg::ST_CONV && fc_rise
        && st_reg.fcw != 16'h0000 && !data_rst |=> conv_abort_out)
        else $error("fast clear in window did not abort");
    a_fc_gap: assert property (conv_abort_out |-> st_reg.fsm == aec_pkg::ST_CLR
        && st_reg.tmr == aec_pkg::CLEAR_CYC - 8'h01)
        else $error("clear interval after fast clear wrong");
    a_eob_count: assert property (end_of_block_valid_out |->
        end_of_block_word_out == {aec_pkg::EOB_TAG, $past(st_reg.evcnt)})
        else $error("end word lacks event count");
    a_full_ptr: assert property (end_of_block_valid_out
        && st_reg.wptr == st_reg.rptr |-> full && !empty)
        else $error("full flag wrong");
    a_data_reset: assert property (st_reg.bset2[aec_pkg::BIT_CLRDATA] |=>
        peak_clear_out && st_reg.evcnt == 24'h000000 && st_reg.wptr == 5'h00)
        else $error("held data reset not applied");
    a_ss_reset: assert property (st_reg.ss_wr |=> st_reg.ctrl1 == 16'h0000
        || $past(do_wr))
        else $error("single-shot write did not reset");
    // Lockout, busy and reset checks.
    a_chain_stop: assert property (st_reg.jmp_q[1] && st_reg.cb_q[1]
        |=> !conv_start_out)
        else $error("gate accepted while chain busy");
    a_veto_block: assert property (st_reg.veto_q[1]
        |=> !conv_start_out)
        else $error("gate accepted under veto");
    a_fc_window: assert property (st_reg.fcw == 16'h0000
        |=> !conv_abort_out)
        else $error("abort outside fast-clear window");
    a_busy_start: assert property (conv_start_out
        |=> busy_out)
        else $error("busy missing after start");
    a_busy_end: assert property (st_reg.fsm == aec_pkg::ST_IDLE && !full && !data_rst
        && !st_reg.ctrl1[aec_pkg::BIT_MTEST] |=> !busy_out)
        else $error("busy held while idle");
    a_mtest_busy: assert property (st_reg.ctrl1[aec_pkg::BIT_MTEST]
        |=> busy_out)
        else $error("memory test not busy");
    a_led_config: assert property (st_reg.cfg != 9'h000
        |=> busy_led_out)
        else $error("busy LED off while configuring");
    a_front_reset: assert property (rst_rise
        |=> peak_clear_out && st_reg.evcnt == 24'h000000)
        else $error("front reset did not clear data");
    a_front_scope: assert property (rst_rise && st_reg.ctrl1[aec_pkg::BIT_SCOPE] && !do_wr
        |=> st_reg.fcwin == aec_pkg::FCWIN_RST)
        else $error("front reset did not reset registers");
    a_sw_hold: assert property (st_reg.bset1[aec_pkg::BIT_SWRST] && !do_wr
        |=> st_reg.ctrl1 == 16'h0000)
        else $error("held software reset not applied");

    c_conv: cover property (conv_start_out ##[1:300] end_of_block_valid_out);
    c_abort: cover property (conv_start_out ##[1:300] conv_abort_out);
    c_full: cover property (full);
    // Covers for lockout and reset paths.
    c_veto: cover property (gate_rise && st_reg.veto_q[1]);
    c_scope: cover property (rst_rise && st_reg.ctrl1[aec_pkg::BIT_SCOPE]);
endmodule : aec_ctrl
`default_nettype wire

// ==== test/aec_conv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module aec_conv_model (
    // Clock and reset.
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // Converter handshake.
    input  wire logic       conv_start_in,
    input  wire logic       conv_abort_in,
    input  wire logic [7:0] latency_in,
    output logic            conv_done_out
);
    logic [7:0] left_reg;
    logic       run_reg;
    // Counts out one conversion and reports its end once.
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            left_reg      <= 8'h00;
            run_reg       <= 1'b0;
            conv_done_out <= 1'b0;
        end
        else
        begin
            conv_done_out <= 1'b0;
            if (conv_abort_in)
                run_reg <= 1'b0;
            else if (conv_start_in)
            begin
                left_reg <= latency_in;
                run_reg  <= 1'b1;
            end
            else if (run_reg)
            begin
                left_reg <= left_reg - 8'h01;
                if (left_reg == 8'h00)
                begin
                    run_reg       <= 1'b0;
                    conv_done_out <= 1'b1;
                end
            end
        end
    end
endmodule : aec_conv_model
`default_nettype wire

// ==== test/acq_event_busy_reset_ctrl_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module acq_event_busy_reset_ctrl_test;
    logic        sys_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [5:0]  avs_address_in = 6'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic        gate_in = 1'b0, veto_in = 1'b0, fast_clear_in = 1'b0;
    logic        reset_pulse_in = 1'b0, chain_busy_in = 1'b0, busy_scope_jumper_in = 1'b0;
    logic [31:0] avs_readdata_out, end_of_block_word_out, eob_seen;
    logic        avs_waitrequest_out, busy_out, busy_oe_out, busy_led_out, conv_done_in;
    logic        conv_start_out, conv_abort_out, peak_clear_out, end_of_block_valid_out;
    logic        data_ready_out;
    logic [7:0]  lat = 8'h3C;
    logic [15:0] r;
    int          err_total = 0, compares = 0, n_start = 0, n_abort = 0, n_eob = 0;
    int          cnt = 0, i, s0, a0, e0;

    always #2.5 sys_clk_in = ~sys_clk_in;

    aec_ctrl aec_ctrl_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .gate_in(gate_in), .veto_in(veto_in),
        .fast_clear_in(fast_clear_in), .reset_pulse_in(reset_pulse_in),
        .chain_busy_in(chain_busy_in), .busy_scope_jumper_in(busy_scope_jumper_in),
        .busy_out(busy_out), .busy_oe_out(busy_oe_out), .busy_led_out(busy_led_out),
        .conv_done_in(conv_done_in), .conv_start_out(conv_start_out),
        .conv_abort_out(conv_abort_out), .peak_clear_out(peak_clear_out),
        .end_of_block_word_out(end_of_block_word_out),
        .end_of_block_valid_out(end_of_block_valid_out), .data_ready_out(data_ready_out));

    aec_conv_model aec_conv_model_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .conv_start_in(conv_start_out), .conv_abort_in(conv_abort_out),
        .latency_in(lat), .conv_done_out(conv_done_in));

    // Tallies the one-cycle pulses of the acquisition side.
    always @(posedge sys_clk_in)
    begin
        if (conv_start_out === 1'b1)
            n_start <= n_start + 1;
        if (conv_abort_out === 1'b1)
            n_abort <= n_abort + 1;
        if (end_of_block_valid_out === 1'b1)
            eob_seen <= end_of_block_word_out;
        if (end_of_block_valid_out === 1'b1)
            n_eob <= n_eob + 1;
    end

    task automatic end_of_test;
        begin
            $display("mismatches %0d compares %0d", err_total, compares);
            if (err_total == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            compares++;
            if (g !== e)
            begin
                err_total++;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc

    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
        int n;
        begin
            n = 0;
            @(posedge sys_clk_in);
            avs_address_in   <= a;
            avs_writedata_in <= {16'h0000, d};
            avs_write_in     <= wr;
            avs_read_in      <= ~wr;
            do
            begin
                @(posedge sys_clk_in);
                n++;
            end
            while (avs_waitrequest_out !== 1'b0 && n < 20);
            if (n >= 20)
            begin
                err_total++;
                end_of_test();
            end
            r = avs_readdata_out[15:0];
            avs_write_in <= 1'b0;
            avs_read_in  <= 1'b0;
        end
    endtask : bus

    task automatic rdchk(input logic [5:0] a, input logic [15:0] e, input string nm);
        begin
            bus(1'b0, a, 16'h0000);
            chk(nm, {16'h0000, e}, {16'h0000, r});
        end
    endtask : rdchk

    task automatic gate;
        begin
            gate_in <= 1'b1;
            cyc(10);
            gate_in <= 1'b0;
            cyc(2);
        end
    endtask : gate

    task automatic wait_idle;
        int n;
        begin
            n = 0;
            cyc(4);
            while (busy_out !== 1'b0 && n < 600)
            begin
                cyc(1);
                n++;
            end
            if (n >= 600)
                err_total++;
            if (n >= 600)
                end_of_test();
            cyc(2);
        end
    endtask : wait_idle

    initial
    begin
        cyc(4);
        rst_n_in <= 1'b1;
        cyc(1);
        chk("led cfg", 1, busy_led_out);
        rdchk(aec_pkg::OFS_BSET2, 16'h4000, "bset2");
        rdchk(aec_pkg::OFS_FCWIN, 16'h0028, "fcwin");
        rdchk(6'h3C, 16'h0000, "unmapped");
        for (i = 0; i < 400 && busy_led_out !== 1'b0; i++)
            cyc(1);
        chk("led off", 0, busy_led_out);
        gate();
        cnt++;
        chk("busy pin", 3, {busy_out, busy_oe_out});
        rdchk(aec_pkg::OFS_STAT1, 16'h000C, "stat busy");
        gate();
        cnt++;
        wait_idle();
        chk("starts", 1, n_start);
        chk("eob", {aec_pkg::EOB_TAG, 24'(cnt)}, eob_seen);
        rdchk(aec_pkg::OFS_EVLO, 16'(cnt), "evlo");
        rdchk(aec_pkg::OFS_EVHI, 16'h0000, "evhi");
        bus(1'b1, aec_pkg::OFS_RDINC, 16'h0000);
        cyc(2);
        chk("drained", 0, data_ready_out);
        bus(1'b1, aec_pkg::OFS_BCLR2, 16'h4000);
        veto_in <= 1'b1;
        gate();
        veto_in <= 1'b0;
        gate();
        cnt++;
        gate();
        wait_idle();
        chk("starts", 2, n_start);
        rdchk(aec_pkg::OFS_EVLO, 16'(cnt), "evlo acc");
        bus(1'b1, aec_pkg::OFS_BSET2, 16'h0004);
        cyc(3);
        chk("peak clr", 1, peak_clear_out);
        gate();
        rdchk(aec_pkg::OFS_EVLO, 16'h0000, "evlo drst");
        rdchk(aec_pkg::OFS_BSET2, 16'h0004, "bset2 drst");
        bus(1'b1, aec_pkg::OFS_BCLR2, 16'h0004);
        chk("starts", 2, n_start);
        chk("buf clr", 0, data_ready_out);
        bus(1'b1, aec_pkg::OFS_FCWIN, 16'h0030);
        bus(1'b1, aec_pkg::OFS_BSET1, 16'h0080);
        rdchk(aec_pkg::OFS_BSET2, 16'h4000, "bset2 swr");
        rdchk(aec_pkg::OFS_FCWIN, 16'h0028, "fcwin swr");
        bus(1'b1, aec_pkg::OFS_BCLR1, 16'h0080);
        rdchk(aec_pkg::OFS_BSET1, 16'h0000, "bset1");
        bus(1'b1, aec_pkg::OFS_FCWIN, 16'h0030);
        bus(1'b1, aec_pkg::OFS_SSRST, 16'h0000);
        rdchk(aec_pkg::OFS_FCWIN, 16'h0028, "fcwin ss");
        for (i = 0; i < 2; i++)
        begin
            bus(1'b1, aec_pkg::OFS_CTRL1, (i == 1) ? 16'h0010 : 16'h0000);
            bus(1'b1, aec_pkg::OFS_FCWIN, 16'h0030);
            gate();
            wait_idle();
            reset_pulse_in <= 1'b1;
            cyc(4);
            reset_pulse_in <= 1'b0;
            cyc(8);
            rdchk(aec_pkg::OFS_EVLO, 16'h0000, "evlo frst");
            chk("buf frst", 0, data_ready_out);
            rdchk(aec_pkg::OFS_FCWIN, (i == 1) ? 16'h0028 : 16'h0030, "fcwin frst");
        end
        cnt = 0;
        lat <= 8'h64;
        {s0, a0, e0} = {n_start, n_abort, n_eob};
        gate_in <= 1'b1;
        cyc(5);
        fast_clear_in <= 1'b1;
        cyc(6);
        fast_clear_in <= 1'b0;
        gate_in <= 1'b0;
        cyc(4);
        chk("abort", a0 + 1, n_abort);
        gate();
        cnt += 2;
        wait_idle();
        chk("starts fc", s0 + 1, n_start);
        chk("eob fc", e0, n_eob);
        gate();
        cnt++;
        cyc(50);
        fast_clear_in <= 1'b1;
        cyc(6);
        fast_clear_in <= 1'b0;
        wait_idle();
        chk("abort late", a0 + 1, n_abort);
        chk("eob late", {aec_pkg::EOB_TAG, 24'(cnt)}, eob_seen);
        busy_scope_jumper_in <= 1'b1;
        chain_busy_in <= 1'b1;
        gate();
        chk("starts chain", s0 + 2, n_start);
        busy_scope_jumper_in <= 1'b0;
        gate();
        chain_busy_in <= 1'b0;
        wait_idle();
        chk("starts own", s0 + 3, n_start);
        bus(1'b1, aec_pkg::OFS_CTRL1, 16'h0040);
        cyc(3);
        chk("busy mtest", 3, {busy_out, busy_led_out});
        rdchk(aec_pkg::OFS_STAT1, 16'h000D, "stat mtest");
        bus(1'b1, aec_pkg::OFS_CTRL1, 16'h0000);
        wait_idle();
        bus(1'b1, aec_pkg::OFS_FCWIN, 16'h0030);
        rst_n_in <= 1'b0;
        cyc(4);
        rst_n_in <= 1'b1;
        cyc(1);
        chk("led hwr", 1, busy_led_out);
        chk("buf hwr", 0, data_ready_out);
        rdchk(aec_pkg::OFS_FCWIN, 16'h0028, "fcwin hwr");
        rdchk(aec_pkg::OFS_EVLO, 16'h0000, "evlo hwr");
        lat <= 8'h02;
        for (i = 0; i < 31; i++)
        begin
            gate();
            wait_idle();
        end
        gate();
        rdchk(aec_pkg::OFS_STAT1, 16'h000F, "stat full");
        bus(1'b1, aec_pkg::OFS_RDINC, 16'h0000);
        wait_idle();
        rdchk(aec_pkg::OFS_STAT1, 16'h0001, "stat not full");
        end_of_test();
    end
endmodule : acq_event_busy_reset_ctrl_test
`default_nettype wire
